// file: rtl/gyro_ctrl_pkg.sv
// constants for the gyro operational control register bank
package gyro_ctrl_pkg;
  localparam logic [5:0]  DAC_OFS       = 6'h30;
  localparam logic [5:0]  IO_OFS        = 6'h32;
  localparam logic [5:0]  SAMPLE_OFS    = 6'h36;
  localparam logic [5:0]  RANGE_OFS     = 6'h38;
  localparam logic [5:0]  SLEEP_OFS     = 6'h3a;
  localparam logic [5:0]  COMMAND_OFS   = 6'h3e;
  localparam logic [15:0] DAC_RST       = 16'h0000;
  localparam logic [15:0] IO_RST        = 16'h0000;
  localparam logic [15:0] SAMPLE_RST    = 16'h0001;
  localparam logic [15:0] RANGE_RST     = 16'h0402;
  localparam logic [15:0] SLEEP_RST     = 16'h0000;
  localparam int          BASE_SEL_BIT  = 7;
  localparam int          RANGE_LSB     = 8;
  localparam int          DAC_LATCH_BIT = 2;
  localparam int          DIR0_BIT      = 9;
  localparam int          DIR1_BIT      = 8;
  localparam int          LVL0_BIT      = 1;
  localparam int          LVL1_BIT      = 0;
  localparam logic [2:0]  RANGE_320     = 3'h4;
  localparam logic [2:0]  RANGE_160     = 3'h2;
  localparam logic [2:0]  RANGE_80      = 3'h1;
  localparam logic [3:0]  MIN_TAPS_160  = 4'h2;
  localparam logic [3:0]  MIN_TAPS_80   = 4'h4;
  localparam logic [3:0]  MAX_TAPS      = 4'h7;
  localparam int          DATA_W        = 14;
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          BASE_FAST_NS  = 1953000;
  localparam int          BASE_SLOW_NS  = 60540000;
  localparam int          SLEEP_UNIT_NS = 500000000;
  localparam int          BASE_FAST_CYC = BASE_FAST_NS / CLK_PERIOD_NS;
  localparam int          BASE_SLOW_CYC = BASE_SLOW_NS / CLK_PERIOD_NS;
  localparam int          SLEEP_UNIT_CYC = SLEEP_UNIT_NS / CLK_PERIOD_NS;
endpackage

// file: rtl/gyro_operational_control.sv
// register bank, sample timer, sleep timer, smoothing filter, dac latch, io lines
`timescale 1ns/100ps
module gyro_operational_control #(
  parameter int unsigned BASE_FAST_CYCLES = gyro_ctrl_pkg::BASE_FAST_CYC,
  parameter int unsigned BASE_SLOW_CYCLES = gyro_ctrl_pkg::BASE_SLOW_CYC,
  parameter int unsigned SLEEP_UNIT_CYCLES = gyro_ctrl_pkg::SLEEP_UNIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wr_en,
  input  wire logic [5:0]  wr_addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        rd_en,
  input  wire logic [5:0]  rd_addr,
  output logic      [7:0]  rd_data,
  input  wire logic        cs_n,
  input  wire logic [13:0] raw_rate,
  input  wire logic [1:0]  dio_in,
  input  wire logic [1:0]  drdy_claim,
  input  wire logic [1:0]  drdy_level,
  input  wire logic [1:0]  alarm_claim,
  input  wire logic [1:0]  alarm_level,
  output logic             sample_tick,
  output logic             sleeping,
  output logic      [13:0] rate_out,
  output logic             rate_valid,
  output logic      [2:0]  range_sel,
  output logic      [11:0] dac_level,
  output logic      [1:0]  dio_out,
  output logic      [1:0]  dio_oe
);
  logic [7:0]  rd_data_reg;
  logic        sample_tick_reg;
  logic        sleeping_reg;
  logic [11:0] dac_code_reg;
  logic [11:0] dac_level_reg;
  logic [1:0]  io_dir_reg;
  logic [1:0]  io_lvl_reg;
  logic [7:0]  period_reg;
  logic [2:0]  range_reg;
  logic [3:0]  taps_reg;
  logic [7:0]  sleep_cnt_reg;
  logic [31:0] base_cnt_reg;
  logic [6:0]  mult_cnt_reg;
  logic [31:0] half_cnt_reg;
  logic [1:0]  dio_s1_reg;
  logic [1:0]  dio_s2_reg;
  logic        cs_s1_reg;
  logic        cs_s2_reg;
  logic        cs_s3_reg;
  logic [1:0]  dio_out_reg;
  logic [1:0]  dio_oe_reg;

  // byte write decode
  wire        wr_lo       = wr_en & ~wr_addr[0];
  wire        wr_hi       = wr_en & wr_addr[0];
  wire [5:0]  wr_word     = {wr_addr[5:1], 1'b0};
  wire        dac_wr_lo   = wr_lo && wr_word == gyro_ctrl_pkg::DAC_OFS;
  wire        dac_wr_hi   = wr_hi && wr_word == gyro_ctrl_pkg::DAC_OFS;
  wire        io_wr_lo    = wr_lo && wr_word == gyro_ctrl_pkg::IO_OFS;
  wire        io_wr_hi    = wr_hi && wr_word == gyro_ctrl_pkg::IO_OFS;
  wire        period_wr   = wr_lo && wr_word == gyro_ctrl_pkg::SAMPLE_OFS;
  wire        range_wr_lo = wr_lo && wr_word == gyro_ctrl_pkg::RANGE_OFS;
  wire        range_wr_hi = wr_hi && wr_word == gyro_ctrl_pkg::RANGE_OFS;
  wire        sleep_wr    = wr_lo && wr_word == gyro_ctrl_pkg::SLEEP_OFS;
  wire        cmd_wr      = wr_lo && wr_word == gyro_ctrl_pkg::COMMAND_OFS;
  wire        latch_cmd   = cmd_wr && wr_data[gyro_ctrl_pkg::DAC_LATCH_BIT];

  // range code: anything undefined falls back to the widest range
  wire [2:0] range_wr_code = wr_data[2:0];
  wire       range_code_ok = range_wr_code == gyro_ctrl_pkg::RANGE_320 ||
                             range_wr_code == gyro_ctrl_pkg::RANGE_160 ||
                             range_wr_code == gyro_ctrl_pkg::RANGE_80;
  wire [2:0] range_next    = !range_wr_hi ? range_reg :
                             range_code_ok ? range_wr_code :
                             gyro_ctrl_pkg::RANGE_320;
  wire [3:0] taps_req      = range_wr_lo ? wr_data[3:0] : taps_reg;
  wire [3:0] taps_cap      = taps_req > gyro_ctrl_pkg::MAX_TAPS ?
                             gyro_ctrl_pkg::MAX_TAPS : taps_req;
  // clamp again after a range change, so range-then-taps order is not required
  wire [3:0] taps_floor    = range_next == gyro_ctrl_pkg::RANGE_80  ?
                             gyro_ctrl_pkg::MIN_TAPS_80 :
                             range_next == gyro_ctrl_pkg::RANGE_160 ?
                             gyro_ctrl_pkg::MIN_TAPS_160 : 4'h0;
  wire [3:0] taps_next     = taps_cap < taps_floor ? taps_floor : taps_cap;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_code_reg  <= gyro_ctrl_pkg::DAC_RST[11:0];
      dac_level_reg <= gyro_ctrl_pkg::DAC_RST[11:0];
      io_dir_reg    <= {gyro_ctrl_pkg::IO_RST[gyro_ctrl_pkg::DIR1_BIT],
                        gyro_ctrl_pkg::IO_RST[gyro_ctrl_pkg::DIR0_BIT]};
      io_lvl_reg    <= {gyro_ctrl_pkg::IO_RST[gyro_ctrl_pkg::LVL1_BIT],
                        gyro_ctrl_pkg::IO_RST[gyro_ctrl_pkg::LVL0_BIT]};
      period_reg    <= gyro_ctrl_pkg::SAMPLE_RST[7:0];
      range_reg     <= gyro_ctrl_pkg::RANGE_RST[10:8];
      taps_reg      <= gyro_ctrl_pkg::RANGE_RST[3:0];
    end else begin
      if (dac_wr_lo)
        dac_code_reg[7:0] <= wr_data;
      if (dac_wr_hi)
        dac_code_reg[11:8] <= wr_data[3:0];
      if (latch_cmd)
        dac_level_reg <= dac_code_reg;
      if (io_wr_hi)
        io_dir_reg <= {wr_data[gyro_ctrl_pkg::DIR1_BIT - 8],
                       wr_data[gyro_ctrl_pkg::DIR0_BIT - 8]};
      if (io_wr_lo)
        io_lvl_reg <= {wr_data[gyro_ctrl_pkg::LVL1_BIT],
                       wr_data[gyro_ctrl_pkg::LVL0_BIT]};
      if (period_wr)
        period_reg <= wr_data;
      range_reg <= range_next;
      taps_reg  <= taps_next;
    end
  end

  // sample period timer, halted while asleep
  wire [31:0] base_limit = period_reg[gyro_ctrl_pkg::BASE_SEL_BIT] ?
                           BASE_SLOW_CYCLES : BASE_FAST_CYCLES;
  wire        base_done  = base_cnt_reg >= base_limit - 32'h1;
  wire        tick_fire  = !sleeping_reg && base_done &&
                           mult_cnt_reg >= period_reg[6:0];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_cnt_reg    <= 32'h0;
      mult_cnt_reg    <= 7'h0;
      sample_tick_reg <= 1'b0;
    end else begin
      sample_tick_reg <= tick_fire;
      if (sleeping_reg || base_done)
        base_cnt_reg <= 32'h0;
      else
        base_cnt_reg <= base_cnt_reg + 32'h1;
      if (sleeping_reg || tick_fire)
        mult_cnt_reg <= 7'h0;
      else if (base_done)
        mult_cnt_reg <= mult_cnt_reg + 7'h1;
    end
  end

  // sleep timer; chip select is a pin, so synchronise before the edge detector
  wire cs_fall    = cs_s3_reg & ~cs_s2_reg;
  wire half_done  = half_cnt_reg >= SLEEP_UNIT_CYCLES - 32'h1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_s1_reg     <= 1'b1;
      cs_s2_reg     <= 1'b1;
      cs_s3_reg     <= 1'b1;
      sleep_cnt_reg <= gyro_ctrl_pkg::SLEEP_RST[7:0];
      half_cnt_reg  <= 32'h0;
      sleeping_reg  <= 1'b0;
    end else begin
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      if (sleep_wr) begin
        sleep_cnt_reg <= wr_data;
        half_cnt_reg  <= 32'h0;
      end else if (cs_fall) begin
        sleep_cnt_reg <= 8'h0;
        half_cnt_reg  <= 32'h0;
      end else if (sleep_cnt_reg != 8'h0) begin
        half_cnt_reg <= half_done ? 32'h0 : half_cnt_reg + 32'h1;
        if (half_done)
          sleep_cnt_reg <= sleep_cnt_reg - 8'h1;
      end
      sleeping_reg <= sleep_wr ? wr_data != 8'h0 :
                      !cs_fall && sleep_cnt_reg != 8'h0 &&
                      !(half_done && sleep_cnt_reg == 8'h1);
    end
  end

  // smoothing: two cascaded moving averages of 2^M samples each
  logic signed [13:0] stage_in  [0:2];
  logic               stage_vin [0:2];
  logic [3:0]         taps_old_reg;
  wire                flush     = taps_old_reg != taps_reg;
  wire [7:0]          tap_count = 8'h1 << taps_reg;

  assign stage_in[0]  = raw_rate;
  assign stage_vin[0] = sample_tick_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      taps_old_reg <= gyro_ctrl_pkg::RANGE_RST[3:0];
    else
      taps_old_reg <= taps_reg;
  end

  for (genvar g = 0; g < 2; g++) begin : g_avg
    logic signed [13:0] hist [0:127];
    logic [6:0]         ptr_reg;
    logic [7:0]         fill_reg;
    logic signed [20:0] sum_reg;
    logic signed [13:0] avg_reg;
    logic               v_reg;
    wire  [6:0]         old_idx  = ptr_reg - tap_count[6:0];
    wire                old_ok   = fill_reg >= tap_count;
    wire signed [20:0]  old_term = old_ok ? 21'(hist[old_idx]) : 21'sh0;
    wire signed [20:0]  sum_next = sum_reg + 21'(stage_in[g]) - old_term;
    wire signed [20:0]  avg_full = sum_next >>> taps_reg;

    always_ff @(posedge clk) begin
      if (stage_vin[g])
        hist[ptr_reg] <= stage_in[g];
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        ptr_reg  <= 7'h0;
        fill_reg <= 8'h0;
        sum_reg  <= 21'sh0;
        avg_reg  <= 14'sh0;
        v_reg    <= 1'b0;
      end else begin
        v_reg <= stage_vin[g] && !flush;
        if (flush) begin
          fill_reg <= 8'h0;
          sum_reg  <= 21'sh0;
        end else if (stage_vin[g]) begin
          ptr_reg  <= ptr_reg + 7'h1;
          fill_reg <= fill_reg == 8'h80 ? fill_reg : fill_reg + 8'h1;
          sum_reg  <= sum_next;
          avg_reg  <= avg_full[13:0];
        end
      end
    end
    assign stage_in[g+1]  = avg_reg;
    assign stage_vin[g+1] = v_reg;
  end

  // io lines: gpio direction first, then data-ready, then alarm
  logic [1:0] dio_out_next;
  logic [1:0] dio_oe_next;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (io_dir_reg[i]) begin
        dio_oe_next[i]  = 1'b1;
        dio_out_next[i] = io_lvl_reg[i];
      end else if (drdy_claim[i]) begin
        dio_oe_next[i]  = 1'b1;
        dio_out_next[i] = drdy_level[i];
      end else if (alarm_claim[i]) begin
        dio_oe_next[i]  = 1'b1;
        dio_out_next[i] = alarm_level[i];
      end else begin
        dio_oe_next[i]  = 1'b0;
        dio_out_next[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dio_s1_reg  <= 2'h0;
      dio_s2_reg  <= 2'h0;
      dio_out_reg <= 2'h0;
      dio_oe_reg  <= 2'h0;
    end else begin
      dio_s1_reg  <= dio_in;
      dio_s2_reg  <= dio_s1_reg;
      dio_out_reg <= dio_out_next;
      dio_oe_reg  <= dio_oe_next;
    end
  end

  // read mux
  wire [1:0]  lvl_seen = (io_dir_reg & io_lvl_reg) | (~io_dir_reg & dio_s2_reg);
  wire [5:0]  rd_word  = {rd_addr[5:1], 1'b0};
  logic [15:0] rd_word_val;
  always_comb begin
    case (rd_word)
      gyro_ctrl_pkg::DAC_OFS:    rd_word_val = {4'h0, dac_code_reg};
      gyro_ctrl_pkg::IO_OFS:     rd_word_val = {6'h0, io_dir_reg[0], io_dir_reg[1],
                                                6'h0, lvl_seen[0], lvl_seen[1]};
      gyro_ctrl_pkg::SAMPLE_OFS: rd_word_val = {8'h0, period_reg};
      gyro_ctrl_pkg::RANGE_OFS:  rd_word_val = {5'h0, range_reg, 4'h0, taps_reg};
      gyro_ctrl_pkg::SLEEP_OFS:  rd_word_val = {8'h0, sleep_cnt_reg};
      default:                   rd_word_val = 16'h0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      rd_data_reg <= 8'h0;
    else if (rd_en)
      rd_data_reg <= rd_addr[0] ? rd_word_val[15:8] : rd_word_val[7:0];
  end

  assign rd_data     = rd_data_reg;
  assign sample_tick = sample_tick_reg;
  assign sleeping    = sleeping_reg;
  assign rate_out    = g_avg[1].avg_reg;
  assign rate_valid  = g_avg[1].v_reg;
  assign range_sel   = range_reg;
  assign dac_level   = dac_level_reg;
  assign dio_out     = dio_out_reg;
  assign dio_oe      = dio_oe_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_dac_latched;
    latch_cmd ##1 dac_level_reg == $past(dac_code_reg);
  endsequence

  a_dac_latch_copy: assert property (latch_cmd |-> s_dac_latched)
    else $error("dac latch did not copy code");
  a_dac_hold_level: assert property (!latch_cmd |=> $stable(dac_level_reg))
    else $error("dac output moved without latch");
  a_taps_min_160: assert property (range_reg == gyro_ctrl_pkg::RANGE_160 |->
                                   taps_reg >= gyro_ctrl_pkg::MIN_TAPS_160)
    else $error("taps below floor for 160 range");
  a_taps_min_80: assert property (range_reg == gyro_ctrl_pkg::RANGE_80 |->
                                  taps_reg >= gyro_ctrl_pkg::MIN_TAPS_80)
    else $error("taps below floor for 80 range");
  a_range_code_legal: assert property (range_reg == gyro_ctrl_pkg::RANGE_320 ||
                                       range_reg == gyro_ctrl_pkg::RANGE_160 ||
                                       range_reg == gyro_ctrl_pkg::RANGE_80)
    else $error("illegal range code held");
  a_tick_cause: assert property (sample_tick_reg |-> $past(base_done) &&
                                 $past(mult_cnt_reg) >= $past(period_reg[6:0]))
    else $error("sample tick without full period");
  a_sleep_no_tick: assert property (sleeping_reg |=> !sample_tick_reg)
    else $error("sample tick while asleep");
  a_wake_on_cs: assert property (cs_fall && !sleep_wr |=> !sleeping_reg &&
                                 sleep_cnt_reg == 8'h0)
    else $error("chip select did not wake");
  a_zero_no_sleep: assert property (sleep_wr && wr_data == 8'h0 |=>
                                    !sleeping_reg [*2])
    else $error("zero count caused sleep");
  a_gpio_wins: assert property (io_dir_reg[0] |=> dio_oe_reg[0] &&
                                dio_out_reg[0] == $past(io_lvl_reg[0]))
    else $error("gpio did not own line 0");
  // an undefined range code must not leave the filter floor undefined
  a_range_fallback: assert property (range_wr_hi && !range_code_ok |=>
                                     range_reg == gyro_ctrl_pkg::RANGE_320)
    else $error("bad range code not defaulted");
  a_line_released: assert property (!io_dir_reg[1] && !drdy_claim[1] &&
                                    !alarm_claim[1] |=> !dio_oe_reg[1])
    else $error("line 1 driven with no owner");
  a_wake_count_clear: assert property ($fell(sleeping_reg) |->
                                       sleep_cnt_reg == 8'h0)
    else $error("sleep count left after wake");
endmodule

// file: verif/host_model.sv
// host side model: byte-wide register master and chip-select pin
`timescale 1ns/100ps
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output logic            wr_en,
  output logic      [5:0] wr_addr,
  output logic      [7:0] wr_data,
  output logic            rd_en,
  output logic      [5:0] rd_addr,
  output logic            cs_n
);
  // select idles high; the wake task makes the only falling edge, which ends a sleep before its count runs out
  initial begin
    wr_en   = 1'b0;
    wr_addr = 6'h00;
    wr_data = 8'h00;
    rd_en   = 1'b0;
    rd_addr = 6'h00;
    cs_n    = 1'b1;
  end
  // idle cycle after each strobe: no two strobes merge, and the byte rate stays low
  task automatic put(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_addr = a;
    wr_data = d;
    wr_en   = 1'b1;
    @(negedge clk);
    wr_en   = 1'b0;
  endtask
  task automatic get(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    rd_addr = a;
    rd_en   = 1'b1;
    @(negedge clk);
    rd_en   = 1'b0;
    d       = rd_data;
  endtask
  // low byte first
  task automatic put16(input logic [5:0] a, input logic [15:0] d);
    put(a, d[7:0]);
    put(a | 6'h01, d[15:8]);
  endtask
  task automatic get16(input logic [5:0] a, output logic [15:0] d);
    get(a, d[7:0]);
    get(a | 6'h01, d[15:8]);
  endtask
  task automatic wake;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (2) @(negedge clk);
    cs_n = 1'b1;
  endtask
endmodule

// file: verif/gyro_operational_control_bench.sv
// self-checking bench for the operational control block
`timescale 1ns/100ps
module gyro_operational_control_bench;
  localparam int          FB = 4;
  localparam int          SB = 8;
  localparam int          SU = 10;
  localparam logic [5:0]  OFS [5] = '{6'h30, 6'h32, 6'h36, 6'h38, 6'h3a};
  localparam logic [15:0] RST [5] = '{16'h0000, 16'h0000, 16'h0001, 16'h0402, 16'h0000};
  localparam logic [15:0] MSK [4] = '{16'h0fff, 16'h0303, 16'h00ff, 16'h0407};
  logic        clk;
  logic        reset_n;
  logic        wr_en;
  logic [5:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        rd_en;
  logic [5:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        cs_n;
  logic [13:0] raw_rate;
  logic [1:0]  dio_in;
  logic [1:0]  drdy_claim;
  logic [1:0]  drdy_level;
  logic [1:0]  alarm_claim;
  logic [1:0]  alarm_level;
  logic        sample_tick;
  logic        sleeping;
  logic [13:0] rate_out;
  logic        rate_valid;
  logic [2:0]  range_sel;
  logic [11:0] dac_level;
  logic [1:0]  dio_out;
  logic [1:0]  dio_oe;
  int          n_fail;
  int          n_checks;
  int          ticks = 0;
  int          seed;
  gyro_operational_control #(.BASE_FAST_CYCLES(FB), .BASE_SLOW_CYCLES(SB),
    .SLEEP_UNIT_CYCLES(SU)) u_gyro_operational_control (.clk(clk), .reset_n(reset_n),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .cs_n(cs_n), .raw_rate(raw_rate),
    .dio_in(dio_in), .drdy_claim(drdy_claim), .drdy_level(drdy_level),
    .alarm_claim(alarm_claim), .alarm_level(alarm_level), .sample_tick(sample_tick),
    .sleeping(sleeping), .rate_out(rate_out), .rate_valid(rate_valid),
    .range_sel(range_sel), .dac_level(dac_level), .dio_out(dio_out), .dio_oe(dio_oe));
  host_model u_host_model (.clk(clk), .rd_data(rd_data), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .cs_n(cs_n));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (sample_tick === 1'b1) ticks <= ticks + 1;
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // falling edges until tick (0), valid (1) or awake (2)
  task automatic wait_for(input int sel, input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        chk("wait bound", 16'h0001, 16'h0000);
        summarize;
      end
    end while (!(sel == 0 ? sample_tick === 1'b1 : sel == 1 ? rate_valid === 1'b1
                 : sleeping === 1'b0));
  endtask
  function automatic logic [2:0] e_rng(input logic [2:0] c);
    return (c == 3'h4 || c == 3'h2 || c == 3'h1) ? c : 3'h4;
  endfunction
  // floor from the effective range; ceiling is 128 taps
  function automatic logic [3:0] e_taps(input logic [2:0] c, input logic [3:0] t);
    logic [3:0] lo;
    lo = e_rng(c) == 3'h1 ? 4'h4 : e_rng(c) == 3'h2 ? 4'h2 : 4'h0;
    return t < lo ? lo : t > 4'h7 ? 4'h7 : t;
  endfunction
  function automatic logic e_line(input int i, input logic g, input logic lv);
    return g ? lv : drdy_claim[i] ? drdy_level[i] : alarm_level[i];
  endfunction
  initial begin
    logic [15:0] v;
    logic [15:0] r;
    logic [3:0]  cur;
    logic [2:0]  c;
    logic [1:0]  oe;
    int          n;
    int          n0;
    seed = 32'h0178b722;
    n_fail = 0;
    n_checks = 0;
    reset_n = 1'b0;
    raw_rate = 14'h0000;
    {dio_in, drdy_claim, drdy_level, alarm_claim, alarm_level} = 10'h000;
    repeat (5) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    chk("range out", 16'(range_sel), 16'h0004);
    for (int i = 0; i < 5; i++) begin
      u_host_model.get16(OFS[i], r);
      chk("reset value", r, RST[i]);
    end
    for (int i = 0; i < 4; i++) begin
      u_host_model.put16(OFS[i], 16'hffff);
      u_host_model.get16(OFS[i], r);
      chk("unused bits", r, MSK[i]);
    end
    u_host_model.get16(6'h3e, r);
    chk("command read", r, 16'h0000);
    // the long 0xff period may still be running: judge the third interval
    for (int i = 0; i < 6; i++) begin
      v = i == 0 ? 16'h007f : 16'($random(seed)) & 16'h0087;
      u_host_model.put(6'h36, v[7:0]);
      repeat (3) wait_for(0, 4000, n);
      chk("period", 16'(n), 16'((v[7] ? SB : FB) * (int'(v[6:0]) + 1)));
    end
    u_host_model.put(6'h36, 8'h01);
    v = 16'($random(seed));
    u_host_model.put(6'h30, v[7:0]);
    chk("dac held", 16'(dac_level), 16'h0000);
    u_host_model.put(6'h31, v[15:8]);
    u_host_model.put(6'h3e, 8'hfb);
    chk("dac held", 16'(dac_level), 16'h0000);
    u_host_model.put(6'h3e, 8'h04);
    @(negedge clk);
    chk("dac latch", 16'(dac_level), v & 16'h0fff);
    for (int i = 0; i < 12; i++) begin
      v = i == 0 ? 16'h0202 : 16'($random(seed));
      {dio_in, drdy_claim, drdy_level, alarm_claim, alarm_level} = 10'($random(seed));
      u_host_model.put16(6'h32, v);
      repeat (4) @(negedge clk);
      oe = {v[8] | drdy_claim[1] | alarm_claim[1], v[9] | drdy_claim[0] | alarm_claim[0]};
      chk("io enable", 16'(dio_oe), 16'(oe));
      r = 16'({e_line(1, v[8], v[0]), e_line(0, v[9], v[1])} & oe);
      chk("io drive", 16'(dio_out & oe), r);
      v = {6'h00, v[9:8], 6'h00, v[9] ? v[1] : dio_in[0], v[8] ? v[0] : dio_in[1]};
      u_host_model.get16(6'h32, r);
      chk("io readback", r, v);
    end
    cur = 4'h7;
    for (int i = 0; i < 16; i++) begin
      c = i[2:0];
      u_host_model.put(6'h39, {5'($random(seed)), c});
      cur = e_taps(c, cur);
      u_host_model.get16(6'h38, r);
      chk("range reclamp", r, {5'h00, e_rng(c), 4'h0, cur});
      v = i < 8 ? 16'($random(seed)) : 16'(i - 8);
      u_host_model.put(6'h38, v[7:0]);
      cur = e_taps(c, v[3:0]);
      u_host_model.get16(6'h38, r);
      chk("tap clamp", r, {5'h00, e_rng(c), 4'h0, cur});
      chk("range out", 16'(range_sel), 16'(e_rng(c)));
    end
    u_host_model.put(6'h39, 8'h04);
    u_host_model.put(6'h38, 8'h00);
    for (int i = 0; i < 6; i++) begin
      raw_rate = 14'($random(seed));
      wait_for(0, 100, n);
      wait_for(1, 10, n);
      chk("valid delay", 16'(n), 16'h0002);
      chk("one tap", 16'(rate_out), 16'(raw_rate));
    end
    u_host_model.put(6'h38, 8'h02);
    raw_rate = 14'h2a5c;
    repeat (12) wait_for(1, 100, n);
    chk("four taps", 16'(rate_out), 16'h2a5c);
    u_host_model.put(6'h3b, 8'hff);
    @(negedge clk);
    chk("high byte", 16'(sleeping), 16'h0000);
    u_host_model.put(6'h3a, 8'h03);
    @(negedge clk);
    chk("asleep", 16'(sleeping), 16'h0001);
    n0 = ticks;
    wait_for(2, 50, n);
    chk("sleep length", 16'(n > 26 && n < 32), 16'h0001);
    chk("ticks asleep", 16'(ticks - n0), 16'h0000);
    u_host_model.get16(6'h3a, r);
    chk("count cleared", r, 16'h0000);
    u_host_model.put(6'h3a, 8'hc8);
    repeat (20) @(negedge clk);
    chk("long sleep", 16'(sleeping), 16'h0001);
    u_host_model.wake;
    wait_for(2, 8, n);
    u_host_model.get16(6'h3a, r);
    chk("woken count", r, 16'h0000);
    u_host_model.put(6'h3a, 8'h00);
    @(negedge clk);
    chk("zero count", 16'(sleeping), 16'h0000);
    u_host_model.put16(6'h30, 16'h0abc);
    u_host_model.put(6'h3e, 8'h04);
    @(negedge clk);
    reset_n = 1'b0;
    @(negedge clk);
    chk("dac reset", 16'(dac_level), 16'h0000);
    reset_n = 1'b1;
    u_host_model.get16(6'h30, r);
    chk("code reset", r, 16'h0000);
    summarize;
  end
endmodule
